/* core/gpio_ports_params.svh */
// offsets, field layouts and reset values of the two ports
`ifndef GPIO_PORTS_PARAMS_SVH
`define GPIO_PORTS_PARAMS_SVH

`define ADDR_W 16
`define DATA_W 8
`define WIDE_W 8
`define NARROW_W 2
`define WIDE_FUNC_W 5

`define OFS_WIDE_OUT_LATCH 16'h0007
`define OFS_NARROW_OUT_LATCH 16'h0008
`define OFS_WIDE_PIN_READ 16'h0014
`define OFS_NARROW_PIN_READ 16'h0015
`define OFS_WIDE_DIRECTION 16'h0F21
`define OFS_NARROW_DIRECTION 16'h0F22
`define OFS_WIDE_FUNC_SELECT 16'h0F3B
`define OFS_NARROW_FUNC_SELECT 16'h0F3C

`define RST_OUT_LATCH 8'h00
`define RST_DIRECTION 8'h00
`define RST_FUNC_SELECT 8'h00
`define RDATA_IDLE 8'h00

`endif

/* core/gpio_ports_pkg.sv */
// types and address decode shared by the port logic
`include "gpio_ports_params.svh"

package gpio_ports_pkg;

    typedef enum {
        SEL_NONE,
        SEL_WIDE_LATCH,
        SEL_NARROW_LATCH,
        SEL_WIDE_PIN,
        SEL_NARROW_PIN,
        SEL_WIDE_DIR,
        SEL_NARROW_DIR,
        SEL_WIDE_FUNC,
        SEL_NARROW_FUNC
    } reg_sel_e;

    function automatic reg_sel_e decode_addr(input logic [`ADDR_W-1:0] addr);
        case (addr)
            `OFS_WIDE_OUT_LATCH: decode_addr = SEL_WIDE_LATCH;
            `OFS_NARROW_OUT_LATCH: decode_addr = SEL_NARROW_LATCH;
            `OFS_WIDE_PIN_READ: decode_addr = SEL_WIDE_PIN;
            `OFS_NARROW_PIN_READ: decode_addr = SEL_NARROW_PIN;
            `OFS_WIDE_DIRECTION: decode_addr = SEL_WIDE_DIR;
            `OFS_NARROW_DIRECTION: decode_addr = SEL_NARROW_DIR;
            `OFS_WIDE_FUNC_SELECT: decode_addr = SEL_WIDE_FUNC;
            `OFS_NARROW_FUNC_SELECT: decode_addr = SEL_NARROW_FUNC;
            default: decode_addr = SEL_NONE;
        endcase
    endfunction : decode_addr

endpackage : gpio_ports_pkg

/* core/gpio_ports_timer_pin_share.sv */
// two general-purpose ports sharing pins with timer and interrupt peripherals
//
// Operation
// - the wide port has eight pins, each separately input or output.
// - an output latch bit drives its pin low for 0 and high for 1 in output mode, reset 0.
// - a direction bit of 0 means input and 1 means output, both registers reset to 0.
// - in input mode wide pins 7..5 feed interrupts 4..2 and pins 3..0 feed timer inputs.
// - selected wide pins 4..0 output divider, two programmable pulses, timer ch1 and ch0.
// - a wide pin-read bit gives the pin level in input mode and 0 in output mode.
// - the narrow port has bits 1 and 0 only, upper bits of its registers read 0.
// - narrow pins feed timer inputs 3 and 2, and output timer channels 3 and 2 when selected.
// - the wide function-select has writable bits 4..0, bits 7..5 read 0, reset 0.
// - a narrow pin-read bit gives the pin level in input mode and 0, upper bits 0.
//
// Design decision made here: strobed register access.
`timescale 1ns/1ns
`include "gpio_ports_params.svh"

module gpio_ports_timer_pin_share
    import gpio_ports_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic [`ADDR_W-1:0] addr_i,
    input wire logic [`DATA_W-1:0] wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    output logic [`DATA_W-1:0] rdata_o,
    input wire logic [`WIDE_W-1:0] wide_pin_i,
    output logic [`WIDE_W-1:0] wide_pin_o,
    output logic [`WIDE_W-1:0] wide_pin_oe_o,
    input wire logic [`NARROW_W-1:0] narrow_pin_i,
    output logic [`NARROW_W-1:0] narrow_pin_o,
    output logic [`NARROW_W-1:0] narrow_pin_oe_o,
    input wire logic divider_out_i,
    input wire logic prog_pulse_a_out_1_i,
    input wire logic prog_pulse_a_out_0_i,
    input wire logic pulse_out_ch0_i,
    input wire logic pulse_out_ch1_i,
    input wire logic pulse_out_ch2_i,
    input wire logic pulse_out_ch3_i,
    output logic ext_irq_in_4_o,
    output logic ext_irq_in_3_o,
    output logic ext_irq_in_2_o,
    output logic timer_a_in_1_o,
    output logic timer_a_in_0_o,
    output logic timer_in_ch0_o,
    output logic timer_in_ch1_o,
    output logic timer_in_ch2_o,
    output logic timer_in_ch3_o
);

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    reg_sel_e sel;
    logic wr;
    logic rd;

    assign sel = decode_addr(addr_i);
    assign wr = ce_i && we_i;
    assign rd = ce_i && re_i;

    ////////////////////////////////////////////////////////////////////////////
    // control registers

    pin_port_if #(.W(`WIDE_W)) wide_port ();
    pin_port_if #(.W(`NARROW_W)) narrow_port ();

    logic [`WIDE_FUNC_W-1:0] wide_func_q;

    port_reg #(
        .W(`WIDE_W),
        .RST(`RST_OUT_LATCH)
    ) u_wide_latch (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .we_i(wr && sel == SEL_WIDE_LATCH),
        .wdata_i(wdata_i),
        .value_o(wide_port.latch)
    );

    port_reg #(
        .W(`WIDE_W),
        .RST(`RST_DIRECTION)
    ) u_wide_dir (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .we_i(wr && sel == SEL_WIDE_DIR),
        .wdata_i(wdata_i),
        .value_o(wide_port.dir)
    );

    port_reg #(
        .W(`WIDE_FUNC_W),
        .RST(`WIDE_FUNC_W'(`RST_FUNC_SELECT))
    ) u_wide_func (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .we_i(wr && sel == SEL_WIDE_FUNC),
        .wdata_i(wdata_i[`WIDE_FUNC_W-1:0]),
        .value_o(wide_func_q)
    );

    port_reg #(
        .W(`NARROW_W),
        .RST(`NARROW_W'(`RST_OUT_LATCH))
    ) u_narrow_latch (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .we_i(wr && sel == SEL_NARROW_LATCH),
        .wdata_i(wdata_i[`NARROW_W-1:0]),
        .value_o(narrow_port.latch)
    );

    port_reg #(
        .W(`NARROW_W),
        .RST(`NARROW_W'(`RST_DIRECTION))
    ) u_narrow_dir (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .we_i(wr && sel == SEL_NARROW_DIR),
        .wdata_i(wdata_i[`NARROW_W-1:0]),
        .value_o(narrow_port.dir)
    );

    port_reg #(
        .W(`NARROW_W),
        .RST(`NARROW_W'(`RST_FUNC_SELECT))
    ) u_narrow_func (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .we_i(wr && sel == SEL_NARROW_FUNC),
        .wdata_i(wdata_i[`NARROW_W-1:0]),
        .value_o(narrow_port.func)
    );

    // pins 7..5 have no secondary output
    assign wide_port.func = {{(`WIDE_W-`WIDE_FUNC_W){1'b0}}, wide_func_q};

    ////////////////////////////////////////////////////////////////////////////
    // secondary outputs and pin muxes

    assign wide_port.alt = {
        3'h0,
        divider_out_i,
        prog_pulse_a_out_1_i,
        prog_pulse_a_out_0_i,
        pulse_out_ch1_i,
        pulse_out_ch0_i
    };
    assign narrow_port.alt = {pulse_out_ch3_i, pulse_out_ch2_i};
    assign wide_port.pin_in = wide_pin_i;
    assign narrow_port.pin_in = narrow_pin_i;

    port_pin_mux u_wide_mux (
        .port(wide_port.mux)
    );

    port_pin_mux u_narrow_mux (
        .port(narrow_port.mux)
    );

    assign wide_pin_o = wide_port.pin_out;
    assign wide_pin_oe_o = wide_port.pin_oe;
    assign narrow_pin_o = narrow_port.pin_out;
    assign narrow_pin_oe_o = narrow_port.pin_oe;

    ////////////////////////////////////////////////////////////////////////////
    // peripheral inputs, only in input mode

    assign ext_irq_in_4_o = wide_port.pin_rd[7];
    assign ext_irq_in_3_o = wide_port.pin_rd[6];
    assign ext_irq_in_2_o = wide_port.pin_rd[5];
    assign timer_a_in_1_o = wide_port.pin_rd[3];
    assign timer_a_in_0_o = wide_port.pin_rd[2];
    assign timer_in_ch1_o = wide_port.pin_rd[1];
    assign timer_in_ch0_o = wide_port.pin_rd[0];
    assign timer_in_ch3_o = narrow_port.pin_rd[1];
    assign timer_in_ch2_o = narrow_port.pin_rd[0];

    ////////////////////////////////////////////////////////////////////////////
    // read data, one cycle after the strobe

    logic [`DATA_W-1:0] rdata_d;
    logic [`DATA_W-1:0] rdata_q;

    always_comb begin
        rdata_d = `RDATA_IDLE;
        if (rd) begin
            case (sel)
                SEL_WIDE_LATCH: rdata_d = wide_port.latch;
                SEL_WIDE_DIR: rdata_d = wide_port.dir;
                SEL_WIDE_FUNC: rdata_d = wide_port.func;
                SEL_WIDE_PIN: rdata_d = wide_port.pin_rd;
                SEL_NARROW_LATCH: rdata_d = {6'h00, narrow_port.latch};
                SEL_NARROW_DIR: rdata_d = {6'h00, narrow_port.dir};
                SEL_NARROW_FUNC: rdata_d = {6'h00, narrow_port.func};
                SEL_NARROW_PIN: rdata_d = {6'h00, narrow_port.pin_rd};
                default: rdata_d = `RDATA_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_q <= `RDATA_IDLE;
        end else if (ce_i) begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata_o = rdata_q;

endmodule : gpio_ports_timer_pin_share

/* core/pin_port_if.sv */
// carrier between port control registers and pin mux
`timescale 1ns/1ns

interface pin_port_if #(
    parameter int W = 8
);
    logic [W-1:0] latch;
    logic [W-1:0] dir;
    logic [W-1:0] func;
    logic [W-1:0] alt;
    logic [W-1:0] pin_in;
    logic [W-1:0] pin_out;
    logic [W-1:0] pin_oe;
    logic [W-1:0] pin_rd;

    modport ctrl (
        output latch,
        output dir,
        output func,
        output alt,
        output pin_in,
        input pin_out,
        input pin_oe,
        input pin_rd
    );

    modport mux (
        input latch,
        input dir,
        input func,
        input alt,
        input pin_in,
        output pin_out,
        output pin_oe,
        output pin_rd
    );
endinterface : pin_port_if

/* core/port_pin_mux.sv */
// per-bit pin drive selection and input-mode read gating
`timescale 1ns/1ns

module port_pin_mux (
    pin_port_if.mux port
);
    // latch or peripheral output onto the pin
    assign port.pin_out = (port.func & port.alt) | (~port.func & port.latch);
    // pin driven only in output mode
    assign port.pin_oe = port.dir;
    // input-mode level, zero in output mode
    assign port.pin_rd = port.pin_in & ~port.dir;
endmodule : port_pin_mux

/* core/port_reg.sv */
// one control register with reset value and clock enable
`timescale 1ns/1ns

module port_reg
    import gpio_ports_pkg::*;
#(
    parameter int W = 8,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic we_i,
    input wire logic [W-1:0] wdata_i,
    output logic [W-1:0] value_o
);
    logic [W-1:0] value_q;

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            value_q <= RST;
        end else if (ce_i && we_i) begin
            value_q <= wdata_i;
        end
    end

    assign value_o = value_q;
endmodule : port_reg

/* dv/gpio_ports_chk.sv */
// port assertions for the shared-pin ports
`timescale 1ns/1ns
`include "gpio_ports_params.svh"
module gpio_ports_chk
    import gpio_ports_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic [`ADDR_W-1:0] addr_i,
    input wire logic [`DATA_W-1:0] wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    input wire logic [`DATA_W-1:0] rdata_o,
    input wire logic [`WIDE_W-1:0] wide_pin_i,
    input wire logic [`WIDE_W-1:0] wide_pin_oe_o,
    input wire logic [`NARROW_W-1:0] narrow_pin_i,
    input wire logic [`NARROW_W-1:0] narrow_pin_oe_o,
    input wire logic ext_irq_in_4_o,
    input wire logic ext_irq_in_3_o,
    input wire logic ext_irq_in_2_o,
    input wire logic timer_a_in_1_o,
    input wire logic timer_a_in_0_o,
    input wire logic timer_in_ch0_o,
    input wire logic timer_in_ch1_o,
    input wire logic timer_in_ch2_o,
    input wire logic timer_in_ch3_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    ////////////////////////////////////////////////////////////////////////////////
    property p_wdir;
        ce_i && we_i && addr_i == 16'h0F21 |=> wide_pin_oe_o == $past(wdata_i);
    endproperty
    a_wdir: assert property (p_wdir) else $error("wide direction write lost");
    property p_ndir;
        ce_i && we_i && addr_i == 16'h0F22 |=> narrow_pin_oe_o == $past(wdata_i[1:0]);
    endproperty
    a_ndir: assert property (p_ndir) else $error("narrow direction write lost");
    property p_wrd;
        ce_i && re_i && addr_i == 16'h0014 |=> rdata_o == $past(wide_pin_i & ~wide_pin_oe_o);
    endproperty
    a_wrd: assert property (p_wrd) else $error("wide pin read wrong");
    property p_nrd;
        ce_i && re_i && addr_i == 16'h0015 |=>
            rdata_o[1:0] == $past(narrow_pin_i & ~narrow_pin_oe_o);
    endproperty
    a_nrd: assert property (p_nrd) else $error("narrow pin read wrong");
    property p_nhi;
        ce_i && re_i && addr_i inside {16'h0008, 16'h0015, 16'h0F22, 16'h0F3C} |=>
            rdata_o[7:2] == 6'h00;
    endproperty
    a_nhi: assert property (p_nhi) else $error("narrow upper bits not zero");
    property p_irq;
        {ext_irq_in_4_o, ext_irq_in_3_o, ext_irq_in_2_o} == (wide_pin_i[7:5] & ~wide_pin_oe_o[7:5]);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt feed wrong");
    property p_wtmr;
        {timer_a_in_1_o, timer_a_in_0_o, timer_in_ch1_o, timer_in_ch0_o} ==
            (wide_pin_i[3:0] & ~wide_pin_oe_o[3:0]);
    endproperty
    a_wtmr: assert property (p_wtmr) else $error("wide timer feed wrong");
    property p_ntmr;
        {timer_in_ch3_o, timer_in_ch2_o} == (narrow_pin_i & ~narrow_pin_oe_o);
    endproperty
    a_ntmr: assert property (p_ntmr) else $error("narrow timer feed wrong");
    c_wdir: cover property (ce_i && we_i && addr_i == 16'h0F21 && wdata_i == 8'hFF);
    c_wrd: cover property (ce_i && re_i && addr_i == 16'h0014 ##1 rdata_o != 8'h00);
    c_irq: cover property (ext_irq_in_4_o && timer_in_ch3_o);
endmodule : gpio_ports_chk

bind gpio_ports_timer_pin_share gpio_ports_chk i_chk (.*);

/* dv/pin_world.sv */
// far side: pads resolved between the block and external drivers
`timescale 1ns/1ns
module pin_world (
    input wire logic [7:0] wo_i,
    input wire logic [7:0] woe_i,
    input wire logic [7:0] wext_i,
    input wire logic [1:0] no_i,
    input wire logic [1:0] noe_i,
    input wire logic [1:0] next_i,
    output logic [7:0] wpin_o,
    output logic [1:0] npin_o
);
    assign wpin_o = (woe_i & wo_i) | (~woe_i & wext_i);
    assign npin_o = (noe_i & no_i) | (~noe_i & next_i);
endmodule : pin_world

/* dv/test_gpio_ports_timer_pin_share.sv */
// self-checking bench for the shared-pin ports
`timescale 1ns/1ns
module test_gpio_ports_timer_pin_share
    import gpio_ports_pkg::*;
;
    logic clock_i = 0, rst_b_i = 0, ce_i = 1, we_i = 0, re_i = 0;
    logic [15:0] addr_i = 0;
    logic [7:0] wdata_i = 0, rdata_o, wide_pin_i, wide_pin_o, wide_pin_oe_o, wext = 0;
    logic [1:0] narrow_pin_i, narrow_pin_o, narrow_pin_oe_o, next = 0;
    logic divider_out_i = 0, prog_pulse_a_out_1_i = 0, prog_pulse_a_out_0_i = 0;
    logic pulse_out_ch0_i = 0, pulse_out_ch1_i = 0, pulse_out_ch2_i = 0, pulse_out_ch3_i = 0;
    logic ext_irq_in_4_o, ext_irq_in_3_o, ext_irq_in_2_o, timer_a_in_1_o, timer_a_in_0_o;
    logic timer_in_ch0_o, timer_in_ch1_o, timer_in_ch2_o, timer_in_ch3_o;
    logic [15:0] map [8] = '{16'h0007, 16'h0008, 16'h0014, 16'h0015,
                             16'h0F21, 16'h0F22, 16'h0F3B, 16'h0F3C};
    logic [7:0] msk [8] = '{8'hFF, 8'h03, 8'h00, 8'h00, 8'hFF, 8'h03, 8'h1F, 8'h03};
    logic [7:0] d, v, l, dr, f, r;
    integer seed = 66, n_fail = 0, checks = 0;
    always #5 clock_i = ~clock_i;
    gpio_ports_timer_pin_share i_gpio_ports_timer_pin_share (.*);
    pin_world i_pin_world (.wo_i(wide_pin_o), .woe_i(wide_pin_oe_o), .wext_i(wext),
        .no_i(narrow_pin_o), .noe_i(narrow_pin_oe_o), .next_i(next),
        .wpin_o(wide_pin_i), .npin_o(narrow_pin_i));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] drive(input logic [7:0] lat, fs, alt);
        return (fs & alt) | (~fs & lat);
    endfunction : drive
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task wr(input logic [15:0] a, input logic [7:0] x);
        @(posedge clock_i);
        we_i <= 1; addr_i <= a; wdata_i <= x;
        @(posedge clock_i);
        we_i <= 0;
    endtask : wr
    task rd(input logic [15:0] a, output logic [7:0] x);
        @(posedge clock_i);
        re_i <= 1; addr_i <= a;
        @(posedge clock_i);
        re_i <= 0;
        #1 x = rdata_o;
    endtask : rd
    task final_report;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        n_fail++;
        final_report;
    end
    initial begin
        repeat (8) @(posedge clock_i);
        rst_b_i <= 1;
        foreach (map[k]) begin
            rd(map[k], d);
            chk(d, 8'h00);
        end
        repeat (4) begin
            foreach (map[k]) begin
                v = 8'($random(seed));
                wr(map[k], v);
                rd(map[k], d);
                chk(d, v & msk[k]);
            end
        end
        wr(16'h0F00, 8'hFF);
        rd(16'h0F00, d);
        chk(d, 8'h00);
        wr(16'h0F21, 8'h00);
        @(posedge clock_i) ce_i <= 0;
        wr(16'h0F21, 8'hFF);
        ce_i <= 1;
        rd(16'h0F21, d);
        chk(d, 8'h00);
        for (int i = 0; i < 24; i++) begin
            l = 8'($random(seed));
            dr = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($random(seed));
            f = (i == 0) ? 8'hFF : 8'($random(seed));
            r = 8'($random(seed));
            wr(16'h0007, l); wr(16'h0F21, dr); wr(16'h0F3B, f);
            wr(16'h0008, l); wr(16'h0F22, dr); wr(16'h0F3C, f);
            @(posedge clock_i);
            wext <= 8'($random(seed));
            next <= 2'($random(seed));
            {divider_out_i, prog_pulse_a_out_1_i, prog_pulse_a_out_0_i, pulse_out_ch1_i,
                pulse_out_ch0_i, pulse_out_ch3_i, pulse_out_ch2_i} <= r[6:0];
            #1;
            chk(wide_pin_oe_o, dr);
            chk(wide_pin_o & dr, drive(l, f & 8'h1F, {3'h0, r[6:2]}) & dr);
            chk({6'h00, narrow_pin_o & dr[1:0]}, drive(l, f, {6'h00, r[1:0]}) & dr & 8'h03);
            d = {ext_irq_in_4_o, ext_irq_in_3_o, ext_irq_in_2_o, 5'h00};
            chk(d, wext & ~dr & 8'hE0);
            d = {4'h0, timer_a_in_1_o, timer_a_in_0_o, timer_in_ch1_o, timer_in_ch0_o};
            chk(d, wext & ~dr & 8'h0F);
            chk({6'h00, timer_in_ch3_o, timer_in_ch2_o}, {6'h00, next & ~dr[1:0]});
            rd(16'h0014, d);
            chk(d, wext & ~dr);
            rd(16'h0015, d);
            chk(d, {6'h00, next & ~dr[1:0]});
        end
        @(posedge clock_i);
        rst_b_i <= 0;
        wext <= 8'h00;
        next <= 2'h0;
        repeat (2) @(posedge clock_i);
        rst_b_i <= 1;
        chk(wide_pin_oe_o, 8'h00);
        chk({6'h00, narrow_pin_oe_o}, 8'h00);
        foreach (map[k]) begin
            rd(map[k], d);
            chk(d, 8'h00);
        end
        final_report;
    end
endmodule : test_gpio_ports_timer_pin_share
